// >>> kp_defines.svh
// timing counts, addresses and field positions of the key-poll serial link
`ifndef KP_DEFINES_SVH
`define KP_DEFINES_SVH

// ------------------------------------------------------------
// link framing
// ------------------------------------------------------------
`define KP_ADDR_BITS 8
`define KP_KEY_ADDR 8'h43
`define KP_DISP_ADDR 8'h42
`define KP_CTL_BITS 4
`define KP_READ_BITS 31
`define KP_KEY_BITS 30
`define KP_READ_TOTAL 6'h27
`define KP_SEG_3COM 126
`define KP_SEG_4COM 164
`define KP_FRAME_3COM 42
`define KP_FRAME_4COM 41

// ------------------------------------------------------------
// timing, in oscillator periods or in core clock figures
// ------------------------------------------------------------
`define KP_SCAN_T 615
`define KP_RESCAN_T 1230
`define KP_CLK_MHZ 250
`define KP_REFRESH_MS 30
`define KP_REFRESH_CYC (`KP_REFRESH_MS * 1000 * `KP_CLK_MHZ)
`define KP_HALF_DIV 6
`define KP_RC_DIV 16
`define KP_LINK_CYC (2 * `KP_HALF_DIV)
`define KP_WAIT_CYC ((`KP_RESCAN_T + 1) * `KP_RC_DIV + 64)
`define KP_POLL_CYC (`KP_WAIT_CYC + 48 * `KP_LINK_CYC)

`endif

// >>> kp_pkg.sv
// state and struct types of both ends of the key-poll serial link
package kp_pkg;

    // host sequencer and device key scanner states
    typedef enum logic [1:0] {H_IDLE, H_XFER, H_GAP} kp_host_st_t;
    typedef enum logic [1:0] {D_IDLE, D_SCAN, D_RESCAN, D_HOLD} kp_scan_st_t;

    // whole state of the host end
    typedef struct packed {
        kp_host_st_t st;
        logic [7:0] div;
        logic lclk;
        logic ce;
        logic di;
        logic [5:0] cnt;
        logic [5:0] total;
        logic [53:0] tx;
        logic [30:0] rx;
        logic is_read;
        logic [2:0] left;
        logic [1:0] idx;
        logic four;
        logic osc;
        logic [163:0] seg;
        logic [31:0] ref_t;
        logic [31:0] key_t;
        logic late;
        logic busy;
        logic do_s1;
        logic do_s2;
        logic [29:0] keys;
        logic sa;
        logic kvalid;
    } kp_host_s_t;

    // device state on the core clock
    typedef struct packed {
        kp_scan_st_t st;
        logic [29:0] key_s1;
        logic [29:0] key_s2;
        logic [29:0] first;
        logic [29:0] key_data;
        logic sa_s1;
        logic sa_s2;
        logic sa;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic osc_s1;
        logic osc_s2;
        logic ce_s1;
        logic ce_s2;
        logic disp_s1;
        logic disp_s2;
        logic done_s1;
        logic done_s2;
        logic done_s3;
        logic [7:0] rc_div;
        logic [10:0] tcnt;
        logic avail;
        logic oe;
        logic [6:0] rst_hold;
    } kp_dcore_s_t;

    // device state on the link clock
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic av_s1;
        logic av_s2;
        logic [5:0] cnt;
        logic [7:0] addr;
        logic rd_act;
        logic rd_valid;
        logic [30:0] rd;
        logic [3:0] ctl;
        logic osc_sel;
        logic four;
        logic disp_on;
        logic done_t;
    } kp_dlink_s_t;

endpackage

// >>> kp_link_if.sv
// four-wire serial link with open-drain data-out and pull-up
`timescale 1ns/10ps
interface kp_link_if;
    logic lclk;
    logic ce;
    logic di;
    logic do_o;
    logic do_oe;
    logic do_line;

    // pull-up: the line is high unless the device sinks it
    assign do_line = do_oe ? do_o : 1'b1;

    modport dev (input lclk, input ce, input di,
                 output do_o, output do_oe);
    modport host (output lclk, output ce, output di, input do_line);
endinterface

// >>> kp_dev.sv
// device end: key scanner on the core clock, serial port on the link clock
`timescale 1ns/10ps
`include "kp_defines.svh"
module kp_dev
    import kp_pkg::*;
#(
    parameter int RC_DIV = `KP_RC_DIV
) (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // link
    kp_link_if.dev lnk,
    // key matrix, sleep state and oscillator pin
    input wire logic [29:0] i_key_in,
    input wire logic i_sleep_ack,
    input wire logic i_ext_osc,
    // status
    output logic o_display_on,
    output logic o_four_common,
    output logic o_osc_source_select,
    output logic o_key_avail
);

    kp_dcore_s_t qc, dc;
    kp_dlink_s_t ql, dl;
    logic tick;
    logic done_ev;
    logic [7:0] addr_nx;

    // ------------------------------------------------------------
    // core domain: oscillator tick and key scan
    // ------------------------------------------------------------

    // one tick per period of the selected oscillator
    assign tick = qc.osc_s2 ? (qc.ext_s2 & ~qc.ext_s3)
                            : (qc.rc_div == 8'(RC_DIV - 1));
    assign done_ev = qc.done_s2 ^ qc.done_s3;

    // next core state
    always_comb begin
        dc = qc;
        dc.key_s1 = i_key_in;
        dc.key_s2 = qc.key_s1;
        dc.sa_s1 = i_sleep_ack;
        dc.sa_s2 = qc.sa_s1;
        dc.ext_s1 = i_ext_osc;
        dc.ext_s2 = qc.ext_s1;
        dc.ext_s3 = qc.ext_s2;
        dc.osc_s1 = ql.osc_sel;
        dc.osc_s2 = qc.osc_s1;
        dc.ce_s1 = lnk.ce;
        dc.ce_s2 = qc.ce_s1;
        dc.disp_s1 = ql.disp_on;
        dc.disp_s2 = qc.disp_s1;
        dc.done_s1 = ql.done_t;
        dc.done_s2 = qc.done_s1;
        dc.done_s3 = qc.done_s2;
        if (qc.rc_div == 8'(RC_DIV - 1)) begin
            dc.rc_div = 8'h00;
        end else begin
            dc.rc_div = qc.rc_div + 8'h01;
        end
        if (tick) begin
            dc.tcnt = qc.tcnt + 11'h001;
        end
        // stretch reset for the link side: its clock stops during reset
        if (!qc.rst_hold[6]) begin
            dc.rst_hold = qc.rst_hold + 7'h01;
        end
        case (qc.st)
            D_IDLE: begin
                // scanning starts only once display data has been loaded
                if (qc.disp_s2 && (|qc.key_s2)) begin
                    dc.first = qc.key_s2;
                    dc.tcnt = 11'h000;
                    dc.st = D_SCAN;
                end
            end
            D_SCAN, D_RESCAN: begin
                if (tick && qc.tcnt == 11'(`KP_SCAN_T - 1)) begin
                    if (qc.st == D_SCAN && qc.key_s2 != qc.first) begin
                        dc.first = qc.key_s2;
                        dc.tcnt = 11'h000;
                        dc.st = D_RESCAN;
                    end else begin
                        dc.key_data = qc.key_s2;
                        dc.sa = qc.sa_s2;
                        dc.avail = 1'b1;
                        dc.st = D_HOLD;
                    end
                end
            end
            D_HOLD: begin
                // a completed valid read releases the key data
                if (done_ev) begin
                    dc.avail = 1'b0;
                    dc.st = D_IDLE;
                end
            end
            default: dc.st = D_IDLE;
        endcase
        if (!qc.disp_s2 && qc.st != D_HOLD) begin
            dc.st = D_IDLE;
        end
        dc.oe = dc.avail & ~qc.ce_s2;
    end

    // core register; reset clears key data and stops the scan
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            qc <= '0;
        end else if (i_clk_en) begin
            qc <= dc;
        end
    end

    // ------------------------------------------------------------
    // link domain: address, display control and key read-out
    // ------------------------------------------------------------

    assign addr_nx = {lnk.di, ql.addr[7:1]};

    // next link state
    always_comb begin
        dl = ql;
        dl.rst_s1 = ~qc.rst_hold[6]; // held long enough to see lclk edges
        dl.rst_s2 = ql.rst_s1;
        dl.av_s1 = qc.avail;
        dl.av_s2 = ql.av_s1;
        if (ql.rst_s2) begin
            // a frame cut by reset is ignored until chip-select falls
            dl.cnt = 6'h3f;
            dl.addr = 8'h00;
            dl.rd_act = 1'b0;
            dl.rd_valid = 1'b0;
            dl.done_t = 1'b0;
            dl.disp_on = 1'b0;
        end else if (lnk.ce) begin
            if (ql.cnt < 6'(`KP_ADDR_BITS)) begin
                dl.addr = addr_nx;
                if (ql.cnt == 6'(`KP_ADDR_BITS - 1) &&
                    addr_nx == `KP_KEY_ADDR) begin
                    dl.rd_act = 1'b1;
                    // key data only while it is held valid
                    dl.rd_valid = ql.av_s2;
                    dl.rd = ql.av_s2 ? {qc.sa, qc.key_data} : '1;
                end
            end else if (ql.rd_act) begin
                dl.rd = {1'b1, ql.rd[30:1]};
            end else if (ql.cnt < 6'(`KP_ADDR_BITS + `KP_CTL_BITS)) begin
                dl.ctl = {lnk.di, ql.ctl[3:1]};
            end
            if (ql.cnt != 6'h3f) begin
                dl.cnt = ql.cnt + 6'h01;
            end
        end else if (ql.cnt != 6'h00) begin
            // frame end on the fall of chip-select
            if (ql.rd_act && ql.rd_valid) begin
                dl.done_t = ~ql.done_t;
            end
            if (!ql.rd_act && ql.addr == `KP_DISP_ADDR &&
                ql.cnt >= 6'(`KP_ADDR_BITS + `KP_CTL_BITS)) begin
                dl.osc_sel = ql.ctl[3];
                dl.four = ql.ctl[2];
                if (ql.ctl[1:0] == (ql.ctl[2] ? 2'h3 : 2'h2)) begin
                    dl.disp_on = 1'b1;
                end
            end
            dl.cnt = 6'h00;
            dl.rd_act = 1'b0;
        end
    end

    // link register
    always_ff @(posedge lnk.lclk) begin
        ql <= dl;
    end

    // ------------------------------------------------------------
    // pins and status
    // ------------------------------------------------------------

    // open-drain data-out, released through reset and its link-side stretch
    assign lnk.do_o = 1'b0;
    assign lnk.do_oe = ~i_rst & qc.rst_hold[6] &
                       ((ql.rd_act & ~ql.rd[0]) | qc.oe);
    assign o_display_on = ql.disp_on;
    assign o_four_common = ql.four;
    assign o_osc_source_select = ql.osc_sel;
    assign o_key_avail = qc.avail;

endmodule

// >>> kp_host.sv
// host end: display refresh frames and key polling over the serial link
//
// Function
// - three-common image goes as three transfers
// - four-common image goes as four transfers
// - whole image sent within 30 ms
// - device pulls data-out low when keys pending
// - polled mode samples data-out each period
// - poll period exceeds rescan, address, read times
// - reads started with data-out high are invalid
// - matching scans finish within 615 oscillator periods
// - differing scans rescan, 1230 periods total
// - key read sends address 43h first
// - interrupt mode reads on low data-out
// - interrupt mode waits before next check
// - that wait exceeds 1230 oscillator periods
// - data-out held high during reset
// - control bit picks internal or external oscillator
// - reset blanks display, stops scan, clears keys
`timescale 1ns/10ps
`include "kp_defines.svh"
module kp_host
    import kp_pkg::*;
#(
    parameter int HALF_DIV = `KP_HALF_DIV,
    parameter int REFRESH_CYC = `KP_REFRESH_CYC,
    parameter int POLL_CYC = `KP_POLL_CYC,
    parameter int WAIT_CYC = `KP_WAIT_CYC
) (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // link
    kp_link_if.host lnk,
    // display image and refresh request
    input wire logic i_refresh,
    input wire logic [163:0] i_segment_bits,
    input wire logic i_four_common,
    input wire logic i_osc_source_select,
    output logic o_refresh_busy,
    output logic o_refresh_late,
    // key reading
    input wire logic i_irq_mode,
    output logic [29:0] o_key_bits,
    output logic o_sleep_ack_bit,
    output logic o_key_valid
);

    kp_host_s_t q, d;
    logic fall;
    logic [53:0] frame_w;
    logic [5:0] frame_len;

    // ------------------------------------------------------------
    // frame builders
    // ------------------------------------------------------------

    // one per-common display frame, address first, lsb first on the wire
    function automatic logic [53:0] disp_frame(input logic four,
                                               input logic osc,
                                               input logic [1:0] idx,
                                               input logic [163:0] seg);
        logic [163:0] sh;
        logic [41:0] part;
        if (four) begin
            sh = seg >> (int'(idx) * `KP_FRAME_4COM);
            part = {1'b0, sh[40:0]};
        end else begin
            sh = seg >> (int'(idx) * `KP_FRAME_3COM);
            part = sh[41:0];
        end
        return {part, osc, four, idx, `KP_DISP_ADDR};
    endfunction

    // number of falling ticks that a display frame occupies
    function automatic logic [5:0] disp_len(input logic four);
        if (four) begin
            return 6'(`KP_ADDR_BITS + `KP_CTL_BITS + `KP_FRAME_4COM);
        end
        return 6'(`KP_ADDR_BITS + `KP_CTL_BITS + `KP_FRAME_3COM);
    endfunction

    assign frame_w = disp_frame(q.four, q.osc, q.idx, q.seg);
    assign frame_len = disp_len(q.four);

    // link clock falls at the end of its high half
    assign fall = q.lclk && (q.div == 8'(HALF_DIV - 1));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.kvalid = 1'b0;
        // data-out pin synchroniser
        d.do_s1 = lnk.do_line;
        d.do_s2 = q.do_s1;
        // free-running link clock divider
        if (q.div == 8'(HALF_DIV - 1)) begin
            d.div = 8'h00;
            d.lclk = ~q.lclk;
        end else begin
            d.div = q.div + 8'h01;
        end
        // poll or post-read wait timer
        if (q.key_t != 32'h0) begin
            d.key_t = q.key_t - 32'h1;
        end
        // refresh budget watch
        if (q.busy) begin
            d.ref_t = q.ref_t + 32'h1;
            if (q.ref_t == 32'(REFRESH_CYC - 1)) begin
                d.late = 1'b1;
            end
        end
        // accept a new image; its frames take priority over key reads
        if (i_refresh && !q.busy) begin
            d.busy = 1'b1;
            d.left = i_four_common ? 3'h4 : 3'h3;
            d.idx = 2'h0;
            d.seg = i_segment_bits;
            d.four = i_four_common;
            d.osc = i_osc_source_select;
            d.ref_t = 32'h0;
            d.late = 1'b0;
        end
        case (q.st)
            H_IDLE: begin
                if (fall) begin
                    if (q.left != 3'h0) begin
                        d.tx = frame_w >> 1;
                        d.di = frame_w[0];
                        d.total = frame_len;
                        d.is_read = 1'b0;
                        d.ce = 1'b1;
                        d.cnt = 6'h01;
                        d.st = H_XFER;
                    end else if (q.key_t == 32'h0 && !q.do_s2) begin
                        // key pending seen with chip-select low
                        d.tx = {46'h0, `KP_KEY_ADDR} >> 1;
                        d.di = 1'(`KP_KEY_ADDR);
                        d.total = `KP_READ_TOTAL;
                        d.is_read = 1'b1;
                        d.ce = 1'b1;
                        d.cnt = 6'h01;
                        d.st = H_XFER;
                    end else if (q.key_t == 32'h0 && !i_irq_mode) begin
                        // nothing pending: wait one more poll period
                        d.key_t = 32'(POLL_CYC);
                    end
                end
            end
            H_XFER: begin
                if (fall) begin
                    if (q.cnt == q.total) begin
                        d.ce = 1'b0;
                        d.di = 1'b0;
                        d.st = H_GAP;
                        if (q.is_read) begin
                            // read began on a low data-out, so data is valid
                            d.keys = q.rx[29:0];
                            d.sa = q.rx[30];
                            d.kvalid = 1'b1;
                            d.key_t = i_irq_mode ? 32'(WAIT_CYC)
                                                 : 32'(POLL_CYC);
                        end else begin
                            d.left = q.left - 3'h1;
                            d.idx = q.idx + 2'h1;
                            if (q.left == 3'h1) begin
                                d.busy = 1'b0;
                            end
                        end
                    end else begin
                        d.di = q.tx[0];
                        d.tx = q.tx >> 1;
                        if (q.is_read && q.cnt >= 6'(`KP_ADDR_BITS)) begin
                            d.rx = {q.do_s2, q.rx[30:1]};
                        end
                        d.cnt = q.cnt + 6'h01;
                    end
                end
            end
            H_GAP: begin
                // chip-select stays low for one whole link period
                if (fall) begin
                    d.st = H_IDLE;
                end
            end
            default: d.st = H_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            q <= '0;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign lnk.lclk = q.lclk;
    assign lnk.ce = q.ce;
    assign lnk.di = q.di;
    assign o_refresh_busy = q.busy;
    assign o_refresh_late = q.late;
    assign o_key_bits = q.keys;
    assign o_sleep_ack_bit = q.sa;
    assign o_key_valid = q.kvalid;

endmodule

// >>> kp_link_asserts.sv
// concurrent checks on the wires of the key-poll serial link
`timescale 1ns/10ps
module kp_link_asserts (
    // core clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // link wires
    input wire logic lclk,
    input wire logic ce,
    input wire logic di,
    input wire logic do_o,
    input wire logic do_oe,
    input wire logic do_line
);
    logic [10:0] hi_q;
    logic [10:0] lo_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // run lengths of chip-select high and low, low one saturates
    always_ff @(posedge i_core_clk) begin
        hi_q <= (ce && !i_rst) ? hi_q + 11'h1 : 11'h0;
        lo_q <= (ce || i_rst) ? 11'h0 : lo_q + {10'h0, lo_q != 11'h7ff};
    end

    a_reset_do_high: assert property (disable iff (1'b0) i_rst |-> do_line)
        else $error("data-out not high during reset");
    a_drain_only_low: assert property (do_oe |-> do_o == 1'b0)
        else $error("data-out driven high");
    a_ce_on_fall: assert property ($changed(ce) |-> $fell(lclk))
        else $error("chip-select moved off a link clock fall");
    a_di_on_fall: assert property ($changed(di) |-> $fell(lclk))
        else $error("serial data moved off a link clock fall");
    a_lclk_half_period: assert property ($changed(lclk) |=> $stable(lclk) [*5])
        else $error("link clock half period too short");
    a_ce_low_gap: assert property ($fell(ce) |-> !ce [*8])
        else $error("chip-select gap too short");
    a_frame_length: assert property ($fell(ce) |-> hi_q inside {[11'd460:11'd660]})
        else $error("frame length out of range");
    a_pending_holds: assert property (!ce && lo_q > 11'd24 && !do_line |=> !do_line || ce)
        else $error("key pending dropped without a read");
    a_bit_on_edge: assert property (ce && hi_q > 11'd24 && $changed(do_line) |-> $rose(lclk))
        else $error("read bit changed off a link clock rise");
endmodule

// >>> testbench.sv
// self-checking bench: host and device ends joined across the serial link
`timescale 1ns/10ps
module testbench;
    import kp_pkg::*;
    localparam int POLL = 3200;
    localparam int WAIT = 2600;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic refresh = 1'b0;
    logic four = 1'b0;
    logic osc = 1'b0;
    logic irq = 1'b0;
    logic sleep = 1'b0;
    logic ext = 1'b0;
    logic [163:0] img = '0;
    logic [29:0] keys = '0;
    logic busy, late, kvalid, sa, disp_on, four_o, osc_o, avail;
    logic [29:0] kbits, exp_keys, alt_keys, ka;
    logic exp_sa = 1'b0;
    logic saw_low = 1'b0;
    logic [63:0] fr = '0;
    logic [63:0] fd = '1;
    int bad_count = 0;
    int num_checks = 0;
    int seed = 32'h6e3cd482;
    int cyc = 0;
    int last_v = 0;
    int nb = 0;
    int frames = 0;
    int exp_idx = 0;

    kp_link_if lnk ();
    kp_host #(.HALF_DIV(6), .REFRESH_CYC(20000), .POLL_CYC(POLL),
        .WAIT_CYC(WAIT)) i_kp_host (.i_core_clk(clk), .i_rst(rst),
        .i_clk_en(1'b1), .lnk(lnk), .i_refresh(refresh),
        .i_segment_bits(img), .i_four_common(four),
        .i_osc_source_select(osc), .o_refresh_busy(busy),
        .o_refresh_late(late), .i_irq_mode(irq), .o_key_bits(kbits),
        .o_sleep_ack_bit(sa), .o_key_valid(kvalid));
    kp_dev #(.RC_DIV(2)) i_kp_dev (.i_core_clk(clk), .i_rst(rst),
        .i_clk_en(1'b1), .lnk(lnk), .i_key_in(keys), .i_sleep_ack(sleep),
        .i_ext_osc(ext), .o_display_on(disp_on), .o_four_common(four_o),
        .o_osc_source_select(osc_o), .o_key_avail(avail));
    kp_link_asserts i_kp_link_asserts (.i_core_clk(clk), .i_rst(rst),
        .lclk(lnk.lclk), .ce(lnk.ce), .di(lnk.di), .do_o(lnk.do_o),
        .do_oe(lnk.do_oe), .do_line(lnk.do_line));

    // core clock 4 ns, external oscillator 40 ns
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        forever #20 ext = ~ext;
    end

    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // a stale read while keys are being released may carry either value
    function automatic logic [30:0] pick(input logic [30:0] seen);
        if (seen === {exp_sa, alt_keys}) return seen;
        return {exp_sa, exp_keys};
    endfunction

    // frame model: compare every finished frame with the expected one
    task automatic frame_done();
        int w;
        logic [63:0] e;
        w = four ? 41 : 42;
        e = '0;
        if (fr[7:0] == 8'h42) begin
            e[11:0] = {osc, four, exp_idx[1:0], 8'h42};
            for (int i = 0; i < w; i++) e[12 + i] = img[exp_idx * w + i];
            check("disp_len", nb, 12 + w);
            check("disp_frame", fr, e);
            exp_idx++;
            frames++;
        end else begin
            check("read_addr", fr, 64'h43);
            check("read_len", nb, 39);
            check("read_word", fd[38:8], pick(fd[38:8]));
        end
    endtask

    // wire monitor on the link clock, data sampled at the rising edge
    always @(posedge lnk.lclk) begin
        if (lnk.ce && nb < 64) begin
            fr[nb] = lnk.di;
            fd[nb] = lnk.do_line;
            nb++;
        end else if (nb > 0) begin
            frame_done();
            nb = 0;
            fr = '0;
            fd = '1;
        end
    end

    // user-side monitor: key results and spacing of key reads
    always @(posedge clk) begin
        cyc++;
        if (rst) begin
            nb = 0;
            fr = '0;
            fd = '1;
        end else if (kvalid === 1'b1) begin
            check("key_bits", {sa, kbits}, pick({sa, kbits}));
            if (last_v > 0) check("key_gap", (cyc - last_v) >= (irq ? WAIT : POLL), 1);
            last_v = cyc;
        end
        if (lnk.do_line !== 1'b1) saw_low = 1'b1;
    end

    task automatic press(input logic [29:0] k);
        keys = k;
        exp_keys = k;
        alt_keys = k;
        sleep = 1'($random(seed));
        exp_sa = sleep;
    endtask

    task automatic wait_valid();
        for (int i = 0; i < 4000 && kvalid !== 1'b1; i++) @(negedge clk);
        check("valid_seen", kvalid, 1);
        @(negedge clk);
    endtask

    task automatic release_keys();
        keys = '0;
        exp_keys = '0;
        repeat (3000) @(negedge clk);
    endtask

    task automatic do_refresh(input logic f, input logic o);
        logic [191:0] r;
        int t0;
        r = {$random(seed), $random(seed), $random(seed), $random(seed),
             $random(seed), $random(seed)};
        @(negedge clk);
        img = r[163:0];
        four = f;
        osc = o;
        refresh = 1'b1;
        exp_idx = 0;
        frames = 0;
        t0 = cyc;
        @(negedge clk);
        refresh = 1'b0;
        for (int i = 0; i < 30000 && busy !== 1'b0; i++) @(negedge clk);
        repeat (40) @(negedge clk);
        check("frames", frames, f ? 4 : 3);
        check("late", late, 0);
        check("in_time", (cyc - t0) < 20000, 1);
        check("disp_on", disp_on, 1);
        check("mode", {four_o, osc_o}, {f, o});
    endtask

    // press k1 (then k2 after 300 cycles), time the pending signal
    task automatic key_test(input logic [29:0] k1, input logic [29:0] k2,
                            input int lo, input int hi);
        int t0;
        @(negedge clk);
        press(k1);
        t0 = cyc;
        if (k2 !== k1) begin
            repeat (300) @(negedge clk);
            press(k2);
        end
        for (int i = 0; i < 9000 && lnk.do_line !== 1'b0; i++) @(negedge clk);
        check("scan_time", (cyc - t0) >= lo && (cyc - t0) <= hi, 1);
        wait_valid();
        release_keys();
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        do_refresh(1'b1, 1'b1);
        ka = 30'($random(seed)) | 30'h1;
        key_test(ka, ka, 6140, 6210);
        do_refresh(1'b0, 1'b0);
        ka = 30'($random(seed)) | 30'h2;
        key_test(ka, ka, 1226, 1300);
        key_test(ka, ~ka, 2456, 2540);
        irq = 1'b1;
        press(30'($random(seed)) | 30'h4);
        repeat (3) wait_valid();
        release_keys();
        irq = 1'b0;
        press(30'($random(seed)) | 30'h8);
        for (int i = 0; i < 3000 && lnk.do_line !== 1'b0; i++) @(negedge clk);
        rst = 1'b1;
        repeat (40) @(negedge clk);
        rst = 1'b0;
        last_v = 0;
        repeat (40) @(negedge clk);
        check("rst_disp", disp_on, 0);
        check("rst_avail", avail, 0);
        saw_low = 1'b0;
        repeat (3000) @(negedge clk);
        check("rst_no_scan", saw_low, 0);
        do_refresh(1'b0, 1'b0);
        wait_valid();
        release_keys();
        summarize();
    end

    // watchdog well beyond the expected run length
    initial begin
        #340000;
        bad_count++;
        summarize();
    end
endmodule
